// >>> hw/sbc_pkg.sv
// Purpose: shared constants for the standby and block gating controller
// Assumes: 100 MHz system clock, one clock domain
// Notes:   timing counts in clk_sys cycles
package sbc_pkg;

  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;

  // unlock byte high nibbles, low nibble is arbitrary
  localparam logic [3:0] UNLOCK_FIRST  = 4'h5;
  localparam logic [3:0] UNLOCK_SECOND = 4'hA;

  // nesting level encodings
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_MASK = 2'h1;
  localparam logic [1:0] LVL_NMI  = 2'h2;
  localparam logic [1:0] LVL_EMU  = 2'h3;

  // pll warm-up select codes
  localparam logic [7:0] PLL_WARM_FAST = 8'h01;

  // restore times in microseconds and cycles
  localparam int HALT_RESTORE_US   = 90;
  localparam int STOP_FAST_US      = 3000;
  localparam int STOP_SLOW_US      = 4000;
  localparam int PLL_RAMP_US       = 2000;
  localparam int HALT_RESTORE_CYC  = HALT_RESTORE_US * CLK_MHZ;
  localparam int STOP_FAST_CYC     = STOP_FAST_US * CLK_MHZ;
  localparam int STOP_SLOW_CYC     = STOP_SLOW_US * CLK_MHZ;
  localparam int PLL_RAMP_CYC      = PLL_RAMP_US * CLK_MHZ;

  // block control reset values
  localparam logic [15:0] GATE_RESET = 16'h0000;
  localparam logic [15:0] BRST_RESET = 16'h0000;

  // interrupt array shape
  localparam int IRQ_REGS = 8;
  localparam int IRQ_BITS = 64;

  // operating modes
  typedef enum logic [2:0] {
    SBC_SYSRST, SBC_RUN, SBC_HALT, SBC_STOP, SBC_RESTORE
  } sbc_mode_t;

endpackage

// >>> hw/sbc_wake_eval.sv
// Purpose: decide wake and vectoring from interrupt state
// Assumes: inputs are on clk_sys, no synchronising needed
// Notes:   purely combinational, the top registers its results
`timescale 1ns/1ps
`default_nettype none
module sbc_wake_eval #(
  parameter int NBITS = 64
) (
  input  wire logic [NBITS-1:0] irq_request_bit,
  input  wire logic [NBITS-1:0] irq_enable_bit,
  input  wire logic             wdt_irq,
  input  wire logic             nmi_pending,
  input  wire logic             master_irq_enable,
  input  wire logic [1:0]       interrupt_nesting_level,
  input  wire logic             stop_mode,
  input  wire logic [NBITS-1:0] stop_wake_mask,
  output logic                  wake,
  output logic                  vector,
  output logic                  pending_any
);

  logic [NBITS-1:0] qual;
  logic             mask_wake;
  logic             nmi_vec;
  logic             mask_vec;

  // a maskable source needs both request and enable
  always_comb begin
    qual        = irq_request_bit & irq_enable_bit;
    pending_any = |qual;
    // in stop only external and slave bus sources count
    mask_wake   = stop_mode ? |(qual & stop_wake_mask) : |qual;
    // nmi vectors unless an emulator interrupt is in service
    nmi_vec     = nmi_pending && (interrupt_nesting_level != sbc_pkg::LVL_EMU);
    // maskable vectors only with mie set and level 0 or 1
    mask_vec    = mask_wake && master_irq_enable && (interrupt_nesting_level[1] == 1'b0);
    wake        = nmi_pending || mask_wake || (wdt_irq && !stop_mode);
    vector      = nmi_vec || mask_vec;
  end

endmodule
`default_nettype wire

// >>> hw/sbc_block_ctl.sv
// Purpose: per-peripheral clock gate, reset hold and write block
// Assumes: gate and reset vectors come from software registers
// Notes:   one lane per peripheral, built by a generate loop
`timescale 1ns/1ps
`default_nettype none
module sbc_block_ctl #(
  parameter int NBLK = 64
) (
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic [NBLK-1:0] gate,
  input  wire logic [NBLK-1:0] hold_rst,
  input  wire logic            all_clocks_off,
  input  wire logic            halt_cpu,
  input  wire logic [NBLK-1:0] stop_keep,
  input  wire logic [NBLK-1:0] cpu_side_mask,
  output logic      [NBLK-1:0] clk_en,
  output logic      [NBLK-1:0] blk_rst,
  output logic      [NBLK-1:0] wr_allow,
  output logic      [NBLK-1:0] rd_allow
);

  logic [NBLK-1:0] clk_en_d;
  logic [NBLK-1:0] blk_rst_d;
  logic [NBLK-1:0] wr_allow_d;
  logic [NBLK-1:0] rd_allow_d;

  // one lane per peripheral
  genvar i;
  generate
    for (i = 0; i < NBLK; i++) begin : g_lane
      always_comb begin
        // RQ19: gate stops clock
        // RQ14: stop keeps only listed blocks, halt stops cpu side
        clk_en_d[i] = !gate[i] && !(all_clocks_off && !stop_keep[i]) && !(halt_cpu && cpu_side_mask[i]);
        // RQ20: reset held regardless of clock
        blk_rst_d[i] = hold_rst[i];
        // RQ21: writes need gate bit clear and no reset; stop or halt clock-off does not block them
        wr_allow_d[i] = !gate[i] && !hold_rst[i];
        rd_allow_d[i] = !hold_rst[i];
      end
    end
  endgenerate

  // registered so the top sees clean flop outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_en   <= '1;
      blk_rst  <= '0;
      wr_allow <= '1;
      rd_allow <= '1;
    end else begin
      clk_en   <= clk_en_d;
      blk_rst  <= blk_rst_d;
      wr_allow <= wr_allow_d;
      rd_allow <= rd_allow_d;
    end
  end

endmodule
`default_nettype wire

// >>> hw/sbc_top.sv
// Purpose: standby mode controller with block clock and reset gating
// Assumes: all inputs are clk_sys synchronous logic signals
// Notes:   software register writes arrive as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: on reset release leave system reset and enter program run
// RQ2: halt request stops cpu, peripherals keep chosen clock
// RQ3: halt ends next edge after watchdog or enabled interrupt
// RQ4: two unlock bytes 0x5n then 0xAn must precede stop request
// RQ5: stop forces clocks off, only external or slave bus wakes
// RQ6: pending enabled interrupt cancels any entry, both blocked flags set
// RQ7: stop alone refused for acceptor off, adc, detector settling, flash
// RQ8: two blocked flags read 1 when entry unavailable
// RQ9: nmi wakes; level 3 resumes inline, else vectors
// RQ10: maskable wakes only with request and enable; inline when not allowed
// RQ11: maskable vectors only with mie 1 and level 0 or 1
// RQ12: hardware keeps nesting level on entry and return
// RQ13: software places two no-ops after the standby instruction
// RQ14: halt stops cpu and multiplier; stop keeps few blocks
// RQ15: stop disables sampling of interrupts, comparators, detector
// RQ16: slave bus address match wakes stop; clock restored first
// RQ17: honour 90us halt and 3ms or 4ms stop restore
// RQ18: warm-up select 0x01 ramps pll over about 2 ms
// RQ19: clock gate bit 1 stops the peripheral clock
// RQ20: reset bit 1 holds peripheral reset, clock or not
// RQ21: writes blocked when gated or reset; reads need only no reset
// RQ22: software resets before gating and ungates before release
// RQ23: software reset bit also resets port configuration
module sbc_top #(
  parameter int NBLK          = 64,
  parameter int HALT_RESTORE  = sbc_pkg::HALT_RESTORE_CYC,
  parameter int STOP_FAST     = sbc_pkg::STOP_FAST_CYC,
  parameter int STOP_SLOW     = sbc_pkg::STOP_SLOW_CYC,
  parameter int PLL_RAMP      = sbc_pkg::PLL_RAMP_CYC
) (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          halt_request_bit,
  input  wire logic                          stop_request_bit,
  input  wire logic                          stop_unlock_wr,
  input  wire logic [7:0]                    stop_unlock_reg,
  input  wire logic                          standby_acceptor,
  input  wire logic                          adc_busy,
  input  wire logic                          lvd_settling,
  input  wire logic                          flash_busy,
  input  wire logic [sbc_pkg::IRQ_BITS-1:0]  irq_request_bit,
  input  wire logic [sbc_pkg::IRQ_BITS-1:0]  irq_enable_bit,
  input  wire logic [sbc_pkg::IRQ_BITS-1:0]  stop_wake_mask,
  input  wire logic                          wdt_irq,
  input  wire logic                          nmi_pending,
  input  wire logic                          master_irq_enable,
  input  wire logic                          irq_enter_mask,
  input  wire logic                          irq_enter_nmi,
  input  wire logic                          irq_enter_emu,
  input  wire logic                          irq_return,
  input  wire logic [1:0]                    irq_return_level,
  input  wire logic                          hs_clock_on,
  input  wire logic                          system_clock_is_high,
  input  wire logic [7:0]                    pll_warmup_select,
  input  wire logic [NBLK-1:0]               block_clock_gate_regs,
  input  wire logic [NBLK-1:0]               block_reset_regs,
  input  wire logic [NBLK-1:0]               stop_keep_mask,
  input  wire logic [NBLK-1:0]               cpu_side_mask,
  input  wire logic                          software_reset_bit,
  output logic                               cpu_run,
  output logic                               cpu_vector,
  output logic                               clocks_forced_off,
  output logic                               sampling_disable,
  output logic                               system_clock_high,
  output logic                               pll_ramping,
  output logic                               stop_entry_blocked,
  output logic                               halt_entry_blocked,
  output logic [1:0]                         interrupt_nesting_level,
  output logic [sbc_pkg::IRQ_BITS-1:0]       dac_wake_ignored,
  output logic                               port_cfg_reset,
  output logic [NBLK-1:0]                    blk_clk_en,
  output logic [NBLK-1:0]                    blk_rst,
  output logic [NBLK-1:0]                    blk_wr_allow,
  output logic [NBLK-1:0]                    blk_rd_allow
);

  sbc_pkg::sbc_mode_t mode_q;
  sbc_pkg::sbc_mode_t mode_d;
  logic [1:0]  unlock_q;
  logic [1:0]  unlock_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] ramp_q;
  logic [31:0] ramp_d;
  logic        clk_sel_q;
  logic        clk_sel_d;
  logic        vector_q;
  logic        vector_d;
  logic        hflag_q;
  logic        hflag_d;
  logic        sflag_q;
  logic        sflag_d;
  logic [1:0]  level_q;
  logic [1:0]  level_d;
  logic        port_rst_q;
  logic        wake;
  logic        vector;
  logic        pending_any;
  logic        stop_refused;

  // wake qualification and vectoring choice
  sbc_wake_eval #(
    .NBITS (sbc_pkg::IRQ_BITS)
  ) u_wake (
    .irq_request_bit         (irq_request_bit),
    .irq_enable_bit          (irq_enable_bit),
    .wdt_irq                 (wdt_irq),
    .nmi_pending             (nmi_pending),
    .master_irq_enable       (master_irq_enable),
    .interrupt_nesting_level (level_q),
    .stop_mode               (mode_q == sbc_pkg::SBC_STOP),
    .stop_wake_mask          (stop_wake_mask),
    .wake                    (wake),
    .vector                  (vector),
    .pending_any             (pending_any)
  );

  // per-peripheral gating lanes
  sbc_block_ctl #(
    .NBLK (NBLK)
  ) u_blk (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .gate           (block_clock_gate_regs),
    .hold_rst       (block_reset_regs | {NBLK{software_reset_bit}}),
    .all_clocks_off (mode_q == sbc_pkg::SBC_STOP),
    .halt_cpu       (mode_q == sbc_pkg::SBC_HALT),
    .stop_keep      (stop_keep_mask),
    .cpu_side_mask  (cpu_side_mask),
    .clk_en         (blk_clk_en),
    .blk_rst        (blk_rst),
    .wr_allow       (blk_wr_allow),
    .rd_allow       (blk_rd_allow)
  );

  // RQ7: stop-only refusal causes
  assign stop_refused = !standby_acceptor || adc_busy || lvd_settling || flash_busy;

  // unlock sequence, mode machine and restore timing
  always_comb begin
    mode_d    = mode_q;
    unlock_d  = unlock_q;
    cnt_d     = cnt_q;
    ramp_d    = (ramp_q != 32'h0000_0000) ? ramp_q - 32'h0000_0001 : ramp_q;
    clk_sel_d = clk_sel_q;
    vector_d  = 1'b0;
    // RQ6: pending interrupt blocks both
    // RQ8: flags show availability
    hflag_d   = pending_any;
    sflag_d   = pending_any || stop_refused;
    // RQ4: unlock bytes in order
    if (stop_unlock_wr) begin
      if (stop_unlock_reg[7:4] == sbc_pkg::UNLOCK_FIRST) begin
        unlock_d = 2'd1;
      end else if (unlock_q == 2'd1 && stop_unlock_reg[7:4] == sbc_pkg::UNLOCK_SECOND) begin
        unlock_d = 2'd2;
      end else begin
        unlock_d = 2'd0;
      end
    end
    case (mode_q)
      // RQ1: leave reset into run
      sbc_pkg::SBC_SYSRST: begin
        mode_d = sbc_pkg::SBC_RUN;
      end
      sbc_pkg::SBC_RUN: begin
        clk_sel_d = system_clock_is_high;
        if (stop_request_bit && halt_request_bit) begin
          mode_d = sbc_pkg::SBC_RUN; // simultaneous bits are ignored
        end else if (stop_request_bit && unlock_q == 2'd2) begin
          unlock_d = 2'd0;
          // RQ6: cancel entry when pending
          // RQ5: enter stop with clocks off
          if (!pending_any && !stop_refused) begin
            mode_d = sbc_pkg::SBC_STOP;
          end
        end else if (halt_request_bit && !pending_any) begin
          // RQ2: halt stops cpu only
          mode_d = sbc_pkg::SBC_HALT;
        end
      end
      sbc_pkg::SBC_HALT: begin
        // RQ3: release at next edge
        if (wake) begin
          vector_d = vector;
          if (!system_clock_is_high && !hs_clock_on) begin
            // RQ17: low-speed halt restore
            cnt_d  = 32'(HALT_RESTORE);
            mode_d = sbc_pkg::SBC_RESTORE;
          end else begin
            mode_d = sbc_pkg::SBC_RUN;
          end
        end
      end
      sbc_pkg::SBC_STOP: begin
        // RQ16: slave bus match wakes stop
        // RQ9: nmi wakes too
        if (wake) begin
          vector_d = vector;
          // RQ17: stop restore by warm-up setting
          // RQ18: fast warm-up ramps pll
          if (pll_warmup_select == sbc_pkg::PLL_WARM_FAST) begin
            cnt_d  = 32'(STOP_FAST);
            ramp_d = 32'(PLL_RAMP);
          end else begin
            cnt_d = 32'(STOP_SLOW);
          end
          mode_d = sbc_pkg::SBC_RESTORE;
        end
      end
      sbc_pkg::SBC_RESTORE: begin
        vector_d = vector_q;
        // RQ5: resume on previous clock once restored
        if (cnt_q <= 32'h0000_0001) begin
          cnt_d  = 32'h0000_0000;
          mode_d = sbc_pkg::SBC_RUN;
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      default: begin
        mode_d = sbc_pkg::SBC_RUN;
      end
    endcase
  end

  // RQ12: nesting level on entry and return
  always_comb begin
    level_d = level_q;
    if (irq_enter_emu) begin
      level_d = sbc_pkg::LVL_EMU;
    end else if (irq_enter_nmi) begin
      level_d = sbc_pkg::LVL_NMI;
    end else if (irq_enter_mask) begin
      level_d = sbc_pkg::LVL_MASK;
    end else if (irq_return) begin
      level_d = irq_return_level;
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q     <= sbc_pkg::SBC_SYSRST;
      unlock_q   <= 2'd0;
      cnt_q      <= 32'h0000_0000;
      ramp_q     <= 32'h0000_0000;
      clk_sel_q  <= 1'b0;
      vector_q   <= 1'b0;
      hflag_q    <= 1'b0;
      sflag_q    <= 1'b0;
      level_q    <= sbc_pkg::LVL_NONE;
      port_rst_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      unlock_q   <= unlock_d;
      cnt_q      <= cnt_d;
      ramp_q     <= ramp_d;
      clk_sel_q  <= clk_sel_d;
      vector_q   <= vector_d;
      hflag_q    <= hflag_d;
      sflag_q    <= sflag_d;
      level_q    <= level_d;
      // RQ23: software reset reaches port config
      port_rst_q <= software_reset_bit;
    end
  end

  // outputs, each from a flop; cpu held until restore completes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_run                 <= 1'b0;
      cpu_vector              <= 1'b0;
      clocks_forced_off       <= 1'b0;
      sampling_disable        <= 1'b0;
      system_clock_high       <= 1'b0;
      pll_ramping             <= 1'b0;
      stop_entry_blocked      <= 1'b0;
      halt_entry_blocked      <= 1'b0;
      interrupt_nesting_level <= sbc_pkg::LVL_NONE;
      dac_wake_ignored        <= '0;
      port_cfg_reset          <= 1'b0;
    end else begin
      cpu_run                 <= (mode_d == sbc_pkg::SBC_RUN);
      // RQ10: inline resume unless allowed
      // RQ11: vector pulse on return to run
      cpu_vector              <= vector_d && (mode_d == sbc_pkg::SBC_RUN);
      clocks_forced_off       <= (mode_d == sbc_pkg::SBC_STOP);
      // RQ15: sampling off during stop
      sampling_disable        <= (mode_d == sbc_pkg::SBC_STOP);
      system_clock_high       <= clk_sel_d;
      pll_ramping             <= (ramp_d != 32'h0000_0000);
      stop_entry_blocked      <= sflag_q;
      halt_entry_blocked      <= hflag_q;
      interrupt_nesting_level <= level_q;
      // RQ15: maskable sources outside stop mask never wake stop; nmi still does
      dac_wake_ignored        <= ~stop_wake_mask;
      port_cfg_reset          <= port_rst_q;
    end
  end

endmodule
`default_nettype wire

// >>> test/sbc_top_sva.sv
// Purpose: port checks for the standby and block gating controller
// Assumes: one clock, sync reset, flags two cycles late
// Notes:   a guard counter keeps pipeline reset state out of checks
`timescale 1ns/1ps
`default_nettype none
module sbc_top_sva #(
  parameter int NBLK = 64
) (
  input wire logic            clk_sys,
  input wire logic            reset,
  input wire logic            halt_request_bit,
  input wire logic            stop_request_bit,
  input wire logic            standby_acceptor,
  input wire logic            adc_busy,
  input wire logic            lvd_settling,
  input wire logic            flash_busy,
  input wire logic [63:0]     irq_request_bit,
  input wire logic [63:0]     irq_enable_bit,
  input wire logic            irq_enter_nmi,
  input wire logic            irq_enter_emu,
  input wire logic            software_reset_bit,
  input wire logic [NBLK-1:0] block_clock_gate_regs,
  input wire logic [NBLK-1:0] block_reset_regs,
  input wire logic            cpu_run,
  input wire logic            cpu_vector,
  input wire logic            clocks_forced_off,
  input wire logic            sampling_disable,
  input wire logic            stop_entry_blocked,
  input wire logic            halt_entry_blocked,
  input wire logic [1:0]      interrupt_nesting_level,
  input wire logic            port_cfg_reset,
  input wire logic [NBLK-1:0] blk_clk_en,
  input wire logic [NBLK-1:0] blk_rst,
  input wire logic [NBLK-1:0] blk_wr_allow,
  input wire logic [NBLK-1:0] blk_rd_allow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // edges since reset, keeps $past out of reset
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic       ok;
  logic       pend;
  assign ok   = (up_q == 2'h3);
  assign pend = |(irq_request_bit & irq_enable_bit);
  assign up_d = reset ? 2'h0 : (ok ? up_q : up_q + 2'h1);
  always_ff @(posedge clk_sys) begin
    up_q <= up_d;
  end

  property p_stop_flag;
    ok |-> stop_entry_blocked == $past(pend | !standby_acceptor | adc_busy | lvd_settling | flash_busy, 2);
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop flag mismatch");
  property p_halt_flag;
    ok |-> halt_entry_blocked == $past(pend, 2);
  endproperty
  a_halt_flag: assert property (p_halt_flag) else $error("halt flag mismatch");
  property p_gate;
    ok |-> (blk_clk_en & $past(block_clock_gate_regs)) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("gated lane still clocked");
  property p_hold;
    ok |-> blk_rst == ($past(block_reset_regs) | {NBLK{$past(software_reset_bit)}});
  endproperty
  a_hold: assert property (p_hold) else $error("lane reset mismatch");
  property p_access;
    ok |-> blk_rd_allow == ~blk_rst && blk_wr_allow == (~blk_rst & ~$past(block_clock_gate_regs));
  endproperty
  a_access: assert property (p_access) else $error("lane access mismatch");
  property p_stop_off;
    clocks_forced_off |-> sampling_disable && !cpu_run;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop state inconsistent");
  property p_boot;
    $fell(reset) |-> ##[1:3] cpu_run;
  endproperty
  a_boot: assert property (p_boot) else $error("no run after reset");
  property p_halt;
    cpu_run && halt_request_bit && !stop_request_bit && !pend |=> !cpu_run;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");
  property p_vector;
    cpu_vector |-> $rose(cpu_run);
  endproperty
  a_vector: assert property (p_vector) else $error("vector without restart");
  property p_level;
    irq_enter_nmi && !irq_enter_emu |-> ##[1:2] interrupt_nesting_level == sbc_pkg::LVL_NMI;
  endproperty
  a_level: assert property (p_level) else $error("nmi level not set");
  property p_port;
    ok |-> port_cfg_reset == $past(software_reset_bit, 2);
  endproperty
  a_port: assert property (p_port) else $error("port reset mismatch");
endmodule
bind sbc_top sbc_top_sva #(.NBLK(NBLK)) i_sbc_top_sva (.*);
`default_nettype wire

// >>> test/sbc_core_model.sv
// Purpose: behavioural cpu core beside the standby controller
// Assumes: vector pulse arrives with the run restart
// Notes:   NOP_CYC sets how many in-line instructions run first
`timescale 1ns/1ps
`default_nettype none
module sbc_core_model #(
  parameter int NOP_CYC = 2
) (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  input  wire logic  cpu_vector,
  input  wire logic  ret_req,
  output logic       irq_enter_mask,
  output logic       irq_return,
  output logic [1:0] irq_return_level
);
  int cnt;
  always @(negedge clk_sys) begin
    irq_enter_mask   <= 1'h0;
    irq_return       <= ret_req;
    irq_return_level <= 2'h0;
    if (reset) begin
      cnt <= 0;
    end else if (cpu_vector === 1'h1) begin
      cnt <= NOP_CYC;
    end else if (cnt > 0) begin
      cnt            <= cnt - 1;
      irq_enter_mask <= (cnt == 1);
    end
  end
endmodule
`default_nettype wire

// >>> test/sbc_top_tb.sv
// Purpose: self-checking bench for the standby controller
// Assumes: short restore counts, eight peripheral lanes
// Notes:   row table covers flags and lanes, modes by hand
`timescale 1ns/1ps
`default_nettype none
module sbc_top_tb;
  localparam int NB = 8;
  localparam int SF = 20;
  logic          clk_sys, reset, halt_request_bit, stop_request_bit, stop_unlock_wr, ret_req;
  logic          standby_acceptor, adc_busy, lvd_settling, flash_busy, wdt_irq, nmi_pending;
  logic          master_irq_enable, irq_enter_mask, irq_enter_nmi, irq_enter_emu, irq_return;
  logic          hs_clock_on, system_clock_is_high, software_reset_bit, cpu_run, cpu_vector;
  logic          clocks_forced_off, sampling_disable, system_clock_high, pll_ramping;
  logic          stop_entry_blocked, halt_entry_blocked, port_cfg_reset;
  logic [1:0]    irq_return_level, interrupt_nesting_level;
  logic [7:0]    stop_unlock_reg, pll_warmup_select;
  logic [63:0]   irq_request_bit, irq_enable_bit, stop_wake_mask, dac_wake_ignored;
  logic [NB-1:0] block_clock_gate_regs, block_reset_regs, blk_clk_en, blk_rst, blk_wr_allow, blk_rd_allow;
  int            err_total, n_tests, n;
  // rows: acceptor adc lvd flash pend gate rst -> stop halt, lane 0 clk rst wr rd
  logic [6:0]    ri [9] = '{7'h40, 7'h00, 7'h60, 7'h50, 7'h48, 7'h44, 7'h42, 7'h41, 7'h43};
  logic [5:0]    ro [9] = '{6'h0B, 6'h2B, 6'h2B, 6'h2B, 6'h2B, 6'h3B, 6'h01, 6'h0C, 6'h04};

  sbc_top #(.NBLK(NB), .HALT_RESTORE(20), .STOP_FAST(SF), .STOP_SLOW(30), .PLL_RAMP(24)) i_sbc_top (
    .*, .stop_keep_mask(8'h0F), .cpu_side_mask(8'h80)
  );
  sbc_core_model #(.NOP_CYC(2)) i_sbc_core_model (.*);

  // free-running system clock
  always #5 clk_sys = ~clk_sys;

  task automatic ticks(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait, w counts cycles
  task automatic wait_run(output int w);
    w = 0;
    while (cpu_run !== 1'h1 && w < 100) begin
      ticks(1);
      w++;
    end
  endtask
  // core pulses: {emulator entry, nmi entry, return}
  task automatic lvl(input logic [2:0] k);
    {irq_enter_emu, irq_enter_nmi, ret_req} = k;
    ticks(2);
    {irq_enter_emu, irq_enter_nmi, ret_req} = 3'h0;
    ticks(3);
  endtask
  // halt, try an unenabled source, then wake by src: 0 irq, 1 nmi, 2 watchdog
  task automatic halt_wake(input int src, input logic expv);
    halt_request_bit = 1'h1;
    ticks(1);
    halt_request_bit = 1'h0;
    irq_request_bit[4] = 1'h1;
    ticks(4);
    chk(cpu_run, 1'h0);
    chk(blk_clk_en, 8'h7F);
    irq_request_bit[4] = 1'h0;
    {irq_request_bit[3], nmi_pending, wdt_irq} = 3'h4 >> src;
    wait_run(n);
    chk(n <= 3, 1'h1);
    chk(cpu_vector, expv);
    {irq_request_bit[3], nmi_pending, wdt_irq} = 3'h0;
    ticks(5);
  endtask
  task automatic unlock(input logic [7:0] a, input logic [7:0] b);
    stop_unlock_wr = 1'h1;
    stop_unlock_reg = a;
    ticks(1);
    stop_unlock_reg = b;
    ticks(1);
    stop_unlock_wr = 1'h0;
  endtask
  task automatic stop_try(input logic taken);
    stop_request_bit = 1'h1;
    ticks(1);
    stop_request_bit = 1'h0;
    ticks(3);
    chk(cpu_run, !taken);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // run takes a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    results();
  end

  initial begin
    {clk_sys, halt_request_bit, stop_request_bit, stop_unlock_wr, ret_req, adc_busy} = '0;
    {lvd_settling, flash_busy, wdt_irq, nmi_pending, master_irq_enable, irq_enter_nmi} = '0;
    {irq_enter_emu, system_clock_is_high, software_reset_bit, irq_request_bit, stop_unlock_reg} = '0;
    {block_clock_gate_regs, block_reset_regs, pll_warmup_select, err_total, n_tests} = '0;
    {reset, standby_acceptor, hs_clock_on} = 3'h7;
    irq_enable_bit = 64'h0000_0000_0000_0008;
    stop_wake_mask = 64'h0000_0000_0000_0008;
    ticks(6);
    chk({cpu_run, stop_entry_blocked, halt_entry_blocked, blk_clk_en, blk_rd_allow}, 19'h0_FFFF);
    reset = 1'h0;
    wait_run(n);
    chk(n <= 3, 1'h1);
    // gate order
    // rows gate a lane alone before reset is held; at the end gating is cleared before reset is released
    for (int i = 0; i < 9; i++) begin
      {standby_acceptor, adc_busy, lvd_settling, flash_busy, irq_request_bit[3]} = ri[i][6:2];
      block_clock_gate_regs = {NB{ri[i][1]}};
      block_reset_regs = {NB{ri[i][0]}};
      ticks(3);
      chk({stop_entry_blocked, halt_entry_blocked}, ro[i][5:4]);
      chk({blk_clk_en[0], blk_rst[0], blk_wr_allow[0], blk_rd_allow[0]}, ro[i][3:0]);
    end
    block_clock_gate_regs = '0;
    ticks(1);
    block_reset_regs = '0;
    ticks(3);
    master_irq_enable = 1'h1;
    halt_wake(0, 1'h1);
    chk(interrupt_nesting_level, 2'h1);
    lvl(3'h1);
    master_irq_enable = 1'h0;
    halt_wake(2, 1'h0);
    master_irq_enable = 1'h1;
    lvl(3'h2);
    chk(interrupt_nesting_level, 2'h2);
    halt_wake(0, 1'h0);
    halt_wake(1, 1'h1);
    lvl(3'h1);
    lvl(3'h4);
    chk(interrupt_nesting_level, 2'h3);
    halt_wake(1, 1'h0);
    lvl(3'h1);
    chk(interrupt_nesting_level, 2'h0);
    {hs_clock_on, halt_request_bit} = 2'h1;
    ticks(1);
    {halt_request_bit, wdt_irq} = 2'h1;
    wait_run(n);
    {hs_clock_on, wdt_irq} = 2'h2;
    chk(n > 18 && n < 24, 1'h1);
    unlock(8'hA3, 8'h57);
    stop_try(1'h0);
    adc_busy = 1'h1;
    unlock(8'h5F, 8'hA0);
    stop_try(1'h0);
    {adc_busy, system_clock_is_high, pll_warmup_select} = 10'h101;
    unlock(8'h51, 8'hAE);
    stop_try(1'h1);
    chk({clocks_forced_off, sampling_disable, blk_clk_en}, 10'h30F);
    chk(dac_wake_ignored, ~stop_wake_mask);
    {irq_enable_bit[4], irq_request_bit[4], wdt_irq} = 3'h7;
    ticks(5);
    chk(cpu_run, 1'h0);
    {irq_enable_bit[4], irq_request_bit[4], wdt_irq, system_clock_is_high} = 4'h0;
    irq_request_bit[3] = 1'h1;
    wait_run(n);
    irq_request_bit[3] = 1'h0;
    chk(n >= SF - 2 && n <= SF + 6, 1'h1);
    chk({pll_ramping, system_clock_high, cpu_vector}, 3'h7);
    software_reset_bit = 1'h1;
    ticks(3);
    chk({port_cfg_reset, blk_rst}, 9'h1FF);
    software_reset_bit = 1'h0;
    ticks(3);
    chk({port_cfg_reset, pll_ramping}, 2'h0);
    results();
  end
endmodule
`default_nettype wire
